// File: pkg/omc_consts.svh
// Register offsets, field positions, reset values and timing counts of the operating mode control block.
// Contract
// - Soft reset bit restores every register default except the interrupt status
// - Soft reset bit clears itself afterwards
// - Low battery enable runs detector and comparison
// - Wake timer runs in any mode while enabled, interrupts on expiry
// - Oscillator select: zero RC, one crystal
// - Transmit bit clears after packet sent
// - Receive bit clears on valid packet, single
// - Tune bit keeps PLL on in idle
// - Lowest bit selects ready mode, crystal on
// - Diversity field drives two antenna selects
// - Auto transmit at almost full, idle when empty
// - Low duty cycle wakes receiver each period
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OMC_CTRL1_IDX 8'h07
`define OMC_CTRL2_IDX 8'h08
`define OMC_CTRL1_ADDR 12'h01c
`define OMC_CTRL2_ADDR 12'h020
`define OMC_IRQ_STAT_ADDR 12'h040
`define OMC_IRQ_CLR_ADDR 12'h044
`define OMC_IRQ_EN_ADDR 12'h048
`define OMC_WUT_PERIOD_ADDR 12'h04c
`define OMC_LDC_ON_ADDR 12'h050
`define OMC_STATE_ADDR 12'h054

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OMC_C1_SOFT_RESET 7
`define OMC_C1_BATT_DET 6
`define OMC_C1_WAKE_TIMER 5
`define OMC_C1_OSCSEL 4
`define OMC_C1_TX_ON 3
`define OMC_C1_RX_ON 2
`define OMC_C1_SYNTH_ON 1
`define OMC_C1_READY_ON 0
`define OMC_C2_MULTI_RX 4
`define OMC_C2_AUTO_SEND 3
`define OMC_C2_DUTY_CYCLE 2
`define OMC_C2_RX_FIFO_CLR 1
`define OMC_C2_TX_FIFO_CLR 0
`define OMC_IRQ_WAKE 0
`define OMC_IRQ_BATT 1
`define OMC_IRQ_SENT 2
`define OMC_IRQ_VALID 3

// ----------------------------------------------------------------
// Reset values, diversity codes and prescaler count
// ----------------------------------------------------------------
`define OMC_CTRL1_RST 8'h01
`define OMC_CTRL2_RST 8'h00
`define OMC_WUT_PERIOD_RST 16'h0100
`define OMC_LDC_ON_RST 16'h0010
`define OMC_DIV_CODE_A 3'h0
`define OMC_DIV_CODE_B 3'h1
`define OMC_DIV_CODE_C 3'h2
`define OMC_DIV_CODE_D 3'h3
`define OMC_WUT_PRESCALE 8'hc7

`endif

// File: pkg/omc_pkg.sv
// Types shared by the operating mode control block.
package omc_pkg;
    typedef enum logic [2:0] {
        OMC_IDLE,
        OMC_READY,
        OMC_TUNE,
        OMC_TX,
        OMC_RX
    } omc_mode_t;
endpackage : omc_pkg

// File: hdl/omc_counter.sv
// Reloading down counter that pulses on expiry.
module omc_counter #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] load,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic exp;
    } omc_cnt_state_t;

    omc_cnt_state_t s_reg;
    omc_cnt_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.exp = 1'b0;
        if (!run)
        begin
            s_next.cnt = load;
        end
        else if (tick)
        begin
            if (s_reg.cnt == '0)
            begin
                s_next.cnt = load;
                s_next.exp = 1'b1;
            end
            else
            begin
                s_next.cnt = s_reg.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign expired = s_reg.exp;
endmodule : omc_counter

// File: hdl/omc_div_decode.sv
// Antenna select decode from the diversity field and the radio activity.
module omc_div_decode (
    input wire logic [2:0] code,
    input wire logic active,
    input wire logic algo_ant,
    output logic ant1,
    output logic ant2
);
`include "omc_consts.svh"
    always_comb
    begin
        ant1 = 1'b0;
        ant2 = 1'b0;
        if (active)
        begin
            case (code)
                `OMC_DIV_CODE_A:
                begin
                    ant2 = 1'b1;
                end
                `OMC_DIV_CODE_B:
                begin
                    ant1 = 1'b1;
                end
                `OMC_DIV_CODE_C:
                begin
                    ant2 = 1'b1;
                end
                `OMC_DIV_CODE_D:
                begin
                    ant1 = 1'b1;
                end
                default:
                begin
                    ant1 = algo_ant;
                    ant2 = ~algo_ant;
                end
            endcase
        end
    end
endmodule : omc_div_decode

// File: hdl/omc_top.sv
// Operating mode and function control registers with APB access and interrupt.
//
// Design decision made here: the APB interface to the registers.
module omc_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic packet_sent,
    input wire logic packet_valid,
    input wire logic tx_fifo_almost_full,
    input wire logic tx_fifo_empty,
    input wire logic battery_low,
    input wire logic algo_ant,
    output logic lbd_enable,
    output logic lbd_compare_enable,
    output logic wut_enable,
    output logic low_freq_osc_select,
    output logic pll_enable,
    output logic xtal_enable,
    output logic tx_active,
    output logic rx_active,
    output logic rx_multi_packet,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output logic ant1,
    output logic ant2,
    output logic irq
);
`include "omc_consts.svh"

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [15:0] wut_period;
        logic [15:0] ldc_on;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [7:0] prescale;
        logic [15:0] ldc_cnt;
        logic ldc_rx;
        logic auto_tx;
        logic [31:0] rdata;
        logic irq;
        logic lbd_q;
    } omc_state_t;

    omc_state_t s_reg;
    omc_state_t s_next;
    logic wut_expired;
    logic ant1_c;
    logic ant2_c;
    logic wr_en;
    logic rd_en;
    logic tick;
    logic [3:0] irq_set;
    omc_pkg::omc_mode_t mode;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign tick = (s_reg.prescale == `OMC_WUT_PRESCALE);

    // Wake timer counts in any mode while enabled.
    omc_counter #(
        .W(16)
    ) u_wut (
        .clock(clock),
        .rst(rst),
        .run(s_reg.ctrl1[`OMC_C1_WAKE_TIMER]),
        .tick(tick),
        .load(s_reg.wut_period),
        .expired(wut_expired)
    );

    always_comb
    begin
        if (s_reg.ctrl1[`OMC_C1_TX_ON] || s_reg.auto_tx)
        begin
            mode = omc_pkg::OMC_TX;
        end
        else if (s_reg.ctrl1[`OMC_C1_RX_ON] || s_reg.ldc_rx)
        begin
            mode = omc_pkg::OMC_RX;
        end
        else if (s_reg.ctrl1[`OMC_C1_SYNTH_ON])
        begin
            mode = omc_pkg::OMC_TUNE;
        end
        else if (s_reg.ctrl1[`OMC_C1_READY_ON])
        begin
            mode = omc_pkg::OMC_READY;
        end
        else
        begin
            mode = omc_pkg::OMC_IDLE;
        end
    end

    omc_div_decode u_div (
        .code(s_reg.ctrl2[7:5]),
        .active(mode == omc_pkg::OMC_TX || mode == omc_pkg::OMC_RX),
        .algo_ant(algo_ant),
        .ant1(ant1_c),
        .ant2(ant2_c)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.prescale = tick ? 8'h00 : s_reg.prescale + 8'h01;
        s_next.lbd_q = battery_low && s_reg.ctrl1[`OMC_C1_BATT_DET];
        irq_set = '0;
        irq_set[`OMC_IRQ_WAKE] = wut_expired;
        irq_set[`OMC_IRQ_BATT] = s_next.lbd_q && !s_reg.lbd_q;
        irq_set[`OMC_IRQ_SENT] = packet_sent;
        irq_set[`OMC_IRQ_VALID] = packet_valid;

        // Auto transmit starts at almost full and ends once drained.
        if (s_reg.ctrl2[`OMC_C2_AUTO_SEND] && tx_fifo_almost_full)
        begin
            s_next.auto_tx = 1'b1;
        end
        else if (s_reg.auto_tx && (tx_fifo_empty || !s_reg.ctrl2[`OMC_C2_AUTO_SEND]))
        begin
            s_next.auto_tx = 1'b0;
        end

        // Low duty cycle: receiver on at each wake period for the on time.
        if (s_reg.ctrl2[`OMC_C2_DUTY_CYCLE] && wut_expired)
        begin
            s_next.ldc_rx = 1'b1;
            s_next.ldc_cnt = s_reg.ldc_on;
        end
        else if (s_reg.ldc_rx && tick)
        begin
            if (s_reg.ldc_cnt == 16'h0000)
            begin
                s_next.ldc_rx = 1'b0;
            end
            else
            begin
                s_next.ldc_cnt = s_reg.ldc_cnt - 16'h0001;
            end
        end
        if (!s_reg.ctrl2[`OMC_C2_DUTY_CYCLE])
        begin
            s_next.ldc_rx = 1'b0;
        end

        if (packet_sent)
        begin
            s_next.ctrl1[`OMC_C1_TX_ON] = 1'b0;
        end
        if (packet_valid && !s_reg.ctrl2[`OMC_C2_MULTI_RX])
        begin
            s_next.ctrl1[`OMC_C1_RX_ON] = 1'b0;
        end

        if (wr_en && paddr == `OMC_IRQ_CLR_ADDR)
        begin
            s_next.irq_stat = s_reg.irq_stat & ~pwdata[3:0];
        end
        // A new event wins over a clear in the same cycle.
        s_next.irq_stat = s_next.irq_stat | irq_set;

        if (wr_en)
        begin
            case (paddr)
                `OMC_CTRL1_ADDR:
                begin
                    s_next.ctrl1 = pwdata[7:0];
                end
                `OMC_CTRL2_ADDR:
                begin
                    s_next.ctrl2 = pwdata[7:0];
                end
                `OMC_IRQ_EN_ADDR:
                begin
                    s_next.irq_en = pwdata[3:0];
                end
                `OMC_WUT_PERIOD_ADDR:
                begin
                    s_next.wut_period = pwdata[15:0];
                end
                `OMC_LDC_ON_ADDR:
                begin
                    s_next.ldc_on = pwdata[15:0];
                end
                default:
                begin
                end
            endcase
        end

        s_next.rdata = 32'h0000_0000;
        if (rd_en)
        begin
            case (paddr)
                `OMC_CTRL1_ADDR: s_next.rdata = {24'h000000, s_reg.ctrl1};
                `OMC_CTRL2_ADDR: s_next.rdata = {24'h000000, s_reg.ctrl2};
                `OMC_IRQ_STAT_ADDR: s_next.rdata = {28'h0000000, s_reg.irq_stat};
                `OMC_IRQ_EN_ADDR: s_next.rdata = {28'h0000000, s_reg.irq_en};
                `OMC_WUT_PERIOD_ADDR: s_next.rdata = {16'h0000, s_reg.wut_period};
                `OMC_LDC_ON_ADDR: s_next.rdata = {16'h0000, s_reg.ldc_on};
                `OMC_STATE_ADDR: s_next.rdata = {29'h0000000, mode};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Soft reset restores defaults at once and never reads back as one.
        if (s_next.ctrl1[`OMC_C1_SOFT_RESET])
        begin
            s_next.ctrl1 = `OMC_CTRL1_RST;
            s_next.ctrl2 = `OMC_CTRL2_RST;
            s_next.wut_period = `OMC_WUT_PERIOD_RST;
            s_next.ldc_on = `OMC_LDC_ON_RST;
            s_next.irq_en = 4'h0;
            s_next.auto_tx = 1'b0;
            s_next.ldc_rx = 1'b0;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_en);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.ctrl1 <= `OMC_CTRL1_RST;
            s_reg.ctrl2 <= `OMC_CTRL2_RST;
            s_reg.wut_period <= `OMC_WUT_PERIOD_RST;
            s_reg.ldc_on <= `OMC_LDC_ON_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Read data is registered during setup so the access phase is zero wait.
    assign prdata = s_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign lbd_enable = s_reg.ctrl1[`OMC_C1_BATT_DET];
    assign lbd_compare_enable = s_reg.ctrl1[`OMC_C1_BATT_DET];
    assign wut_enable = s_reg.ctrl1[`OMC_C1_WAKE_TIMER];
    assign low_freq_osc_select = s_reg.ctrl1[`OMC_C1_OSCSEL];
    assign pll_enable = (mode != omc_pkg::OMC_IDLE && mode != omc_pkg::OMC_READY);
    assign xtal_enable = (mode != omc_pkg::OMC_IDLE);
    assign tx_active = (mode == omc_pkg::OMC_TX);
    assign rx_active = (mode == omc_pkg::OMC_RX);
    assign rx_multi_packet = s_reg.ctrl2[`OMC_C2_MULTI_RX];
    assign rx_fifo_clear = s_reg.ctrl2[`OMC_C2_RX_FIFO_CLR];
    assign tx_fifo_clear = s_reg.ctrl2[`OMC_C2_TX_FIFO_CLR];
    assign ant1 = ant1_c;
    assign ant2 = ant2_c;
    assign irq = s_reg.irq;
endmodule : omc_top

// File: test/omc_top_sva.sv
// Port assertions for the operating mode control block.
`include "omc_consts.svh"
module omc_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic packet_sent,
    input wire logic packet_valid,
    input wire logic tx_fifo_almost_full,
    input wire logic tx_fifo_empty,
    input wire logic lbd_enable,
    input wire logic lbd_compare_enable,
    input wire logic wut_enable,
    input wire logic low_freq_osc_select,
    input wire logic pll_enable,
    input wire logic xtal_enable,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic rx_multi_packet,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic w1;
    assign w1 = psel && penable && pwrite && paddr == `OMC_CTRL1_ADDR;
    logic w2;
    logic ldm_on;
    assign w2 = psel && penable && pwrite && paddr == `OMC_CTRL2_ADDR;
    // The low duty cycle window keeps the receiver on past a valid packet, so it is tracked here.
    always_ff @(posedge clock)
    begin
        if (rst || (w1 && pwdata[7]))
        begin
            ldm_on <= 1'b0;
        end
        else if (w2)
        begin
            ldm_on <= pwdata[2];
        end
    end
    chk_soft_reset: assert property (w1 && pwdata[7] |=> (xtal_enable && !pll_enable && !tx_active && !lbd_enable)[*2])
        else $error("soft reset left a control output set");
    chk_lbd_follow: assert property (w1 && !pwdata[7] |=> lbd_enable == $past(pwdata[6]) && lbd_compare_enable == lbd_enable)
        else $error("battery detector enable wrong");
    chk_wut_follow: assert property (w1 && !pwdata[7] |=> wut_enable == $past(pwdata[5]))
        else $error("wake timer enable wrong");
    chk_osc_follow: assert property (w1 && !pwdata[7] |=> low_freq_osc_select == $past(pwdata[4]))
        else $error("oscillator select wrong");
    chk_tx_done: assert property (tx_active && packet_sent && !w1 && !tx_fifo_almost_full && tx_fifo_empty |=> !tx_active)
        else $error("transmit stayed on after packet sent");
    chk_rx_done: assert property (rx_active && packet_valid && !rx_multi_packet && !w1 && !ldm_on |=> !rx_active)
        else $error("receive stayed on after valid packet");
    chk_tune_pll: assert property (w1 && !pwdata[7] && pwdata[1] |=> pll_enable)
        else $error("synthesizer off with tune bit set");
    chk_ready_xtal: assert property (w1 && !pwdata[7] && pwdata[0] |=> xtal_enable)
        else $error("crystal off with ready bit set");
    cov_soft_reset: cover property (w1 && pwdata[7]);
    cov_tx_sent: cover property (tx_active && packet_sent);
    cov_irq: cover property ($rose(irq));
endmodule : omc_sva

bind omc_top omc_sva chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .packet_sent(packet_sent), .packet_valid(packet_valid),
    .tx_fifo_almost_full(tx_fifo_almost_full), .tx_fifo_empty(tx_fifo_empty),
    .lbd_enable(lbd_enable), .lbd_compare_enable(lbd_compare_enable),
    .wut_enable(wut_enable), .low_freq_osc_select(low_freq_osc_select), .pll_enable(pll_enable),
    .xtal_enable(xtal_enable), .tx_active(tx_active), .rx_active(rx_active), .rx_multi_packet(rx_multi_packet),
    .irq(irq));

// File: test/tb_top.sv
// Directed bench for the operating mode control block.
`include "omc_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] C1 = `OMC_CTRL1_ADDR;
    localparam logic [11:0] C2 = `OMC_CTRL2_ADDR;
    localparam logic [11:0] ST = `OMC_IRQ_STAT_ADDR;
    localparam logic [11:0] CL = `OMC_IRQ_CLR_ADDR;
    localparam logic [11:0] EN = `OMC_IRQ_EN_ADDR;
    localparam logic [11:0] MD = `OMC_STATE_ADDR;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic packet_sent = 1'b0;
    logic packet_valid = 1'b0;
    logic battery_low = 1'b0;
    logic tx_fifo_almost_full = 1'b0;
    logic tx_fifo_empty = 1'b1;
    logic algo_ant = 1'b0;
    logic [31:0] prdata, r;
    logic pready, pslverr, lbd_enable, lbd_cmp, wut_enable, osc_sel, pll_enable, xtal_enable;
    logic tx_active, rx_active, rx_multi, rx_clr, tx_clr, ant1, ant2, irq;
    int failures = 0;
    int n_compared = 0;
    int cycle_count = 0;

    omc_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .packet_sent(packet_sent),
        .packet_valid(packet_valid), .tx_fifo_almost_full(tx_fifo_almost_full), .tx_fifo_empty(tx_fifo_empty),
        .battery_low(battery_low), .algo_ant(algo_ant), .lbd_enable(lbd_enable), .lbd_compare_enable(lbd_cmp),
        .wut_enable(wut_enable), .low_freq_osc_select(osc_sel), .pll_enable(pll_enable),
        .xtal_enable(xtal_enable), .tx_active(tx_active), .rx_active(rx_active), .rx_multi_packet(rx_multi),
        .rx_fifo_clear(rx_clr), .tx_fifo_clear(tx_clr), .ant1(ant1), .ant2(ant2), .irq(irq));

    always #2.5 clock = ~clock;

    // ----------------------------------------------------------------
    // Bus cycles and helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Read data is taken at the edge at which pready is sampled high, before the design moves on.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        r = prdata;
        check(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle

    task automatic pulse(input logic sent);
        @(posedge clock);
        packet_sent <= sent;
        packet_valid <= !sent;
        @(posedge clock);
        packet_sent <= 1'b0;
        packet_valid <= 1'b0;
        #1;
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fields();
        apb(1'b0, C1, 32'h0);
        check(r, 32'h01);
        check(xtal_enable, 1'b1);
        apb(1'b1, C1, 32'h71);
        check({lbd_enable, lbd_cmp, wut_enable, osc_sel}, 4'hf);
        apb(1'b1, C1, 32'h01);
        check({lbd_enable, lbd_cmp, wut_enable, osc_sel}, 4'h0);
        apb(1'b1, 12'h3fc, 32'hffffffff);
        apb(1'b0, 12'h3fc, 32'h0);
        check(r, 32'h0);
        $display("test fields done");
    endtask : t_fields

    task automatic t_swres();
        apb(1'b1, C2, 32'h13);
        apb(1'b1, C1, 32'h72);
        check({rx_multi, rx_clr, tx_clr, pll_enable}, 4'hf);
        apb(1'b1, C1, 32'h80);
        check({rx_multi, rx_clr, tx_clr, pll_enable, lbd_enable, xtal_enable}, 6'h01);
        apb(1'b0, C1, 32'h0);
        check(r, 32'h01);
        apb(1'b0, C2, 32'h0);
        check(r, 32'h00);
        apb(1'b1, C2, 32'h02);
        check(rx_clr, 1'b1);
        apb(1'b1, C2, 32'h00);
        check(rx_clr, 1'b0);
        $display("test soft reset done");
    endtask : t_swres

    task automatic t_packets();
        apb(1'b1, CL, 32'h0f);
        apb(1'b1, EN, 32'h04);
        apb(1'b1, C1, 32'h08);
        check(tx_active, 1'b1);
        pulse(1'b1);
        check(tx_active, 1'b0);
        apb(1'b0, C1, 32'h0);
        check(r, 32'h00);
        check(irq, 1'b1);
        apb(1'b1, CL, 32'h04);
        idle(2);
        check(irq, 1'b0);
        apb(1'b1, C2, 32'h10);
        apb(1'b1, C1, 32'h04);
        pulse(1'b0);
        check(rx_active, 1'b1);
        apb(1'b1, C2, 32'h00);
        pulse(1'b0);
        check(rx_active, 1'b0);
        apb(1'b0, ST, 32'h0);
        check(r, 32'h08);
        $display("test packets done");
    endtask : t_packets

    task automatic t_modes();
        apb(1'b1, C1, 32'h02);
        check(pll_enable, 1'b1);
        apb(1'b0, MD, 32'h0);
        check(r, 32'h02);
        apb(1'b1, C1, 32'h01);
        check({pll_enable, xtal_enable}, 2'h1);
        apb(1'b0, MD, 32'h0);
        check(r, 32'h01);
        apb(1'b1, C1, 32'h00);
        check(pll_enable, 1'b0);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, C2, 32'(c) << 5);
            @(posedge clock);
            algo_ant <= c[0];
            apb(1'b1, C1, 32'h08);
            check({ant1, ant2}, c[0] ? 2'h2 : 2'h1);
            apb(1'b1, C1, 32'h00);
            check({tx_active, ant1, ant2}, 3'h0);
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_auto();
        apb(1'b1, C2, 32'h08);
        check(tx_active, 1'b0);
        @(posedge clock);
        tx_fifo_empty <= 1'b0;
        tx_fifo_almost_full <= 1'b1;
        @(posedge clock);
        tx_fifo_almost_full <= 1'b0;
        idle(2);
        check(tx_active, 1'b1);
        @(posedge clock);
        tx_fifo_empty <= 1'b1;
        idle(2);
        check(tx_active, 1'b0);
        apb(1'b1, C2, 32'h00);
        $display("test auto transmit done");
    endtask : t_auto

    // A wake period of one gives an expiry every two prescaler ticks, about 400 clocks.
    task automatic t_timer();
        apb(1'b1, CL, 32'h0f);
        apb(1'b1, EN, 32'h01);
        apb(1'b1, `OMC_WUT_PERIOD_ADDR, 32'h1);
        apb(1'b1, `OMC_LDC_ON_ADDR, 32'h0);
        apb(1'b1, C1, 32'h21);
        idle(450);
        check(irq, 1'b1);
        apb(1'b1, C2, 32'h04);
        repeat (450)
        begin
            if (rx_active !== 1'b1)
                idle(1);
        end
        idle(100);
        check(rx_active, 1'b1);
        idle(200);
        check(rx_active, 1'b0);
        apb(1'b1, C2, 32'h00);
        apb(1'b1, C1, 32'h01);
        apb(1'b1, EN, 32'h00);
        $display("test wake timer done");
    endtask : t_timer

    task automatic t_irq();
        apb(1'b1, CL, 32'h0f);
        apb(1'b1, EN, 32'h02);
        @(posedge clock);
        battery_low <= 1'b1;
        idle(3);
        check(irq, 1'b0);
        @(posedge clock);
        battery_low <= 1'b0;
        apb(1'b1, C1, 32'h41);
        @(posedge clock);
        battery_low <= 1'b1;
        idle(3);
        check(irq, 1'b1);
        apb(1'b1, EN, 32'h00);
        idle(2);
        check(irq, 1'b0);
        apb(1'b1, EN, 32'h02);
        idle(2);
        check(irq, 1'b1);
        apb(1'b1, CL, 32'h02);
        idle(2);
        check(irq, 1'b0);
        @(posedge clock);
        battery_low <= 1'b0;
        $display("test interrupt done");
    endtask : t_irq

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    always @(posedge clock)
    begin
        cycle_count++;
        if (cycle_count == 5000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_fields();
        t_swres();
        t_packets();
        t_modes();
        t_auto();
        t_timer();
        t_irq();
        results();
    end
endmodule : tb_top
